//--- hw/obcl_fetch.v
`timescale 1ns/100ps
`include "obcl_regs.vh"

module obcl_fetch (
    input wire pclk,
    input wire presetn,
    input wire boot_swap,
    output reg flash_rd_r,
    output reg [19:0] flash_addr_r,
    input wire [7:0] flash_rdata,
    input wire flash_rvalid,
    output reg [31:0] bytes_r,
    output reg swap_used_r,
    output reg done_r
);
    localparam ST_IDLE = 3'b001;
    localparam ST_REQ = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [2:0] state_r;
    reg [1:0] idx_r;
    reg [19:0] base_r;

    // Fetch runs once after each reset, then parks in done.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            idx_r <= 2'h0;
            base_r <= `OBCL_PRI_BASE;
            swap_used_r <= 1'b0;
            flash_rd_r <= 1'b0;
            flash_addr_r <= 20'h00000;
            bytes_r <= `OBCL_BYTES_RST;
            done_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // [R2] Boot swap source
                    base_r <= boot_swap ? `OBCL_ALT_BASE : `OBCL_PRI_BASE;
                    swap_used_r <= boot_swap;
                    flash_addr_r <= boot_swap ? `OBCL_ALT_BASE :
                                    `OBCL_PRI_BASE;
                    flash_rd_r <= 1'b1;
                    state_r <= ST_REQ;
                end
                ST_REQ: begin
                    if (flash_rvalid) begin
                        bytes_r[idx_r*8 +: 8] <= flash_rdata;
                        if (idx_r == `OBCL_NUM_BYTES) begin
                            flash_rd_r <= 1'b0;
                            done_r <= 1'b1;
                            state_r <= ST_DONE;
                        end else begin
                            idx_r <= idx_r + 2'h1;
                            flash_addr_r <= base_r +
                                {18'h00000, idx_r + 2'h1};
                        end
                    end
                end
                ST_DONE: begin
                    state_r <= ST_DONE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- hw/obcl_regs.vh
`ifndef OBCL_REGS_VH
`define OBCL_REGS_VH

// Flash locations of the four option bytes, primary and boot-swap copy.
`define OBCL_PRI_BASE 20'h000C0
`define OBCL_ALT_BASE 20'h010C0
`define OBCL_NUM_BYTES 2'h3

// Option byte register indices; byte address is four times the index.
`define OBCL_IDX_WDOG 12'h0C0
`define OBCL_IDX_LVD 12'h0C1
`define OBCL_IDX_RSVD 12'h0C2
`define OBCL_IDX_DBG 12'h0C3

// Block registers at byte addresses.
`define OBCL_ADDR_STATUS 12'h000
`define OBCL_ADDR_MASK 12'h004
`define OBCL_ADDR_CTRL 12'h008
`define OBCL_ADDR_CONFIG 12'h00C

// Watchdog option byte fields.
`define OBCL_WD_IRQ 7
`define OBCL_WD_WIN_HI 6
`define OBCL_WD_WIN_LO 5
`define OBCL_WD_RUN 4
`define OBCL_WD_OVF_HI 3
`define OBCL_WD_OVF_LO 1
`define OBCL_WD_STBY 0

// Low-voltage and debug option byte fields, fixed patterns and full window code.
`define OBCL_LV_OFF 0
`define OBCL_LV_FIXED 7'h7F
`define OBCL_RSVD_FIXED 8'hFF
`define OBCL_DBG_ERASE 0
`define OBCL_DBG_EN 7
`define OBCL_DBG_FIXED_HI 3'h0
`define OBCL_WIN_FULL 2'h3

// Status and mask bits.
`define OBCL_ST_LOADED 0
`define OBCL_ST_PATERR 1
`define OBCL_ST_DBGBAD 2
`define OBCL_ST_LVDOK 3
`define OBCL_ST_W 4

// Reset values.
`define OBCL_STATUS_RST 4'h0
`define OBCL_MASK_RST 4'h0
`define OBCL_BYTES_RST 32'hFFFFFFFF

// Detector settling time after a fast restart: 200 us at 200 MHz.
`define OBCL_LVD_SETTLE_CYC 16'h9C40

`endif

//--- hw/obcl_top.v
// What this block does
// [R1] Option bytes are fetched and applied before the CPU is released.
// [R2] With boot swap, bytes come from the alternate flash copy.
// [R3] Interval-interrupt bit enables the watchdog 75% interval interrupt.
// [R4] Window field selects 25, 50, 75 or 100 percent open period.
// [R5] Window forced to 100 percent when standby running is off.
// [R6] Run-at-reset bit starts or keeps stopped the watchdog counter.
// [R7] Overflow field selects 2^10 up to 2^20 low-speed clock periods.
// [R8] Standby bit stops or keeps the counter running in HALT/STOP.
// [R9] Watchdog keeps counting during self-programming and EEPROM emulation.
// [R10] Low-voltage bit zero enables the detector by default at release.
// [R11] Programmer must write ones into bits 7 to 1 of that byte.
// [R12] No low-voltage detection while the detect-on bit is zero.
// [R13] Default start sets detect-on again when the CPU starts.
// [R14] Detection unreliable 200 us after watchdog or illegal-op reset.
// [R15] Reserved option byte and its copy must be programmed to FFH.
// [R16] Debug code: 00 off, 01 prohibited, 10 erase-on-fail, 11 no erase.
// [R17] Programmer must write 000010B into debug byte bits 6 to 1.
// [R18] Debug byte bits 3 to 1 may be overwritten, not trusted.
// [R19] Decoded configuration latched once per reset and then held.
`timescale 1ns/100ps
`include "obcl_regs.vh"

module obcl_top #(
    parameter [15:0] LVD_SETTLE_CYC = `OBCL_LVD_SETTLE_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire boot_swap,
    output wire flash_rd,
    output wire [19:0] flash_addr,
    input wire [7:0] flash_rdata,
    input wire flash_rvalid,
    input wire rst_by_wdog_or_illegal,
    input wire cpu_halt,
    input wire cpu_stop,
    output reg cpu_release,
    output reg wdog_count_en,
    output reg wdog_interval_irq_en,
    output reg [1:0] wdog_window_sel,
    output reg [4:0] wdog_overflow_exp,
    output reg lvd_enable,
    output reg lvd_unreliable,
    output reg dbg_enable,
    output reg dbg_erase_on_fail,
    output reg irq
);
    // One-hot address decode shared by read and write paths.
    localparam D_STATUS = 0;
    localparam D_MASK = 1;
    localparam D_CTRL = 2;
    localparam D_CONFIG = 3;
    localparam D_WDOG = 4;
    localparam D_LVD = 5;
    localparam D_RSVD = 6;
    localparam D_DBG = 7;

    function [7:0] obcl_dec;
        input [11:0] a;
        begin
            obcl_dec = 8'h00;
            case (a)
                `OBCL_ADDR_STATUS: obcl_dec[D_STATUS] = 1'b1;
                `OBCL_ADDR_MASK: obcl_dec[D_MASK] = 1'b1;
                `OBCL_ADDR_CTRL: obcl_dec[D_CTRL] = 1'b1;
                `OBCL_ADDR_CONFIG: obcl_dec[D_CONFIG] = 1'b1;
                (`OBCL_IDX_WDOG << 2): obcl_dec[D_WDOG] = 1'b1;
                (`OBCL_IDX_LVD << 2): obcl_dec[D_LVD] = 1'b1;
                (`OBCL_IDX_RSVD << 2): obcl_dec[D_RSVD] = 1'b1;
                (`OBCL_IDX_DBG << 2): obcl_dec[D_DBG] = 1'b1;
                default: obcl_dec = 8'h00;
            endcase
        end
    endfunction

    // [R7] Overflow exponent
    function [4:0] obcl_ovf_exp;
        input [2:0] code;
        begin
            case (code)
                3'h0: obcl_ovf_exp = 5'h0A;
                3'h1: obcl_ovf_exp = 5'h0B;
                3'h2: obcl_ovf_exp = 5'h0C;
                3'h3: obcl_ovf_exp = 5'h0D;
                3'h4: obcl_ovf_exp = 5'h0F;
                3'h5: obcl_ovf_exp = 5'h11;
                3'h6: obcl_ovf_exp = 5'h12;
                default: obcl_ovf_exp = 5'h14;
            endcase
        end
    endfunction

    // Bit 2 enable, bit 1 erase on failed check, bit 0 prohibited code.
    function [2:0] obcl_dbg_dec;
        input [7:0] b;
        begin
            obcl_dbg_dec[2] = b[`OBCL_DBG_EN];
            obcl_dbg_dec[1] = b[`OBCL_DBG_EN] & ~b[`OBCL_DBG_ERASE];
            obcl_dbg_dec[0] = ~b[`OBCL_DBG_EN] & b[`OBCL_DBG_ERASE];
        end
    endfunction

    wire [31:0] bytes;
    wire swap_used;
    wire fetch_done;

    obcl_fetch u_fetch (
        .pclk(pclk),
        .presetn(presetn),
        .boot_swap(boot_swap),
        .flash_rd_r(flash_rd),
        .flash_addr_r(flash_addr),
        .flash_rdata(flash_rdata),
        .flash_rvalid(flash_rvalid),
        .bytes_r(bytes),
        .swap_used_r(swap_used),
        .done_r(fetch_done)
    );

    wire [7:0] wd_byte = bytes[7:0];
    wire [7:0] lv_byte = bytes[15:8];
    wire [7:0] rs_byte = bytes[23:16];
    wire [7:0] dbg_byte = bytes[31:24];

    reg loaded_r;
    reg [7:0] opt_wd_r;
    reg [7:0] opt_lv_r;
    reg [7:0] opt_rs_r;
    reg [7:0] opt_dbg_r;
    reg detect_on_r;
    reg [3:0] status_r;
    reg [3:0] mask_r;
    reg [15:0] settle_cnt_r;

    wire load = fetch_done & ~loaded_r;
    wire [7:0] dec = obcl_dec(paddr);
    wire acc_done = psel & penable & pready;
    wire wr = acc_done & pwrite;
    wire setup_rd = psel & penable & ~pready;
    wire standby = cpu_halt | cpu_stop;
    wire [2:0] dbg_mode_new = obcl_dbg_dec(dbg_byte);
    wire [2:0] dbg_mode = obcl_dbg_dec(opt_dbg_r);
    wire [3:0] status_clr = (wr & dec[D_STATUS]) ? pwdata[3:0] : 4'h0;
    wire ro_hit = dec[D_CONFIG] | dec[D_WDOG] | dec[D_LVD] |
                  dec[D_RSVD] | dec[D_DBG];
    wire unmapped = (dec == 8'h00);

    // [R11] Fixed ones field checked
    // [R15] Reserved byte checked
    // [R17] Debug pattern checked
    // [R18] Overwritable debug bits skipped
    wire lv_pat_bad = (lv_byte[7:1] != `OBCL_LV_FIXED);
    wire rs_pat_bad = (rs_byte != `OBCL_RSVD_FIXED);
    wire dbg_pat_bad = (dbg_byte[6:4] != `OBCL_DBG_FIXED_HI);
    wire pat_err = lv_pat_bad | rs_pat_bad | dbg_pat_bad;
    // [R16] Prohibited debug code
    wire dbg_bad = dbg_mode_new[0];
    wire settle_end = lvd_unreliable &
                      (settle_cnt_r == LVD_SETTLE_CYC - 16'h0001);

    // [R19] Latch once per reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_r <= 1'b0;
            opt_wd_r <= 8'hFF;
            opt_lv_r <= 8'hFF;
            opt_rs_r <= 8'hFF;
            opt_dbg_r <= 8'h00;
        end else if (load) begin
            loaded_r <= 1'b1;
            opt_wd_r <= wd_byte;
            opt_lv_r <= lv_byte;
            opt_rs_r <= rs_byte;
            opt_dbg_r <= dbg_byte;
        end
    end

    // Configuration outputs follow the latched bytes, one cycle behind.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_release <= 1'b0;
            lvd_enable <= 1'b0;
        end else begin
            // [R1] Release after apply
            cpu_release <= loaded_r;
            // [R12] Detection follows detect-on
            lvd_enable <= loaded_r & detect_on_r;
        end
    end

    // Watchdog settings; the counter itself lives outside this block.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_count_en <= 1'b0;
            wdog_interval_irq_en <= 1'b0;
            wdog_window_sel <= `OBCL_WIN_FULL;
            wdog_overflow_exp <= 5'h00;
        end else begin
            // [R3] Interval interrupt
            wdog_interval_irq_en <= loaded_r & opt_wd_r[`OBCL_WD_IRQ];
            // [R4] Window select
            // [R5] Forced full window
            wdog_window_sel <= opt_wd_r[`OBCL_WD_STBY] ?
                opt_wd_r[`OBCL_WD_WIN_HI:`OBCL_WD_WIN_LO] : `OBCL_WIN_FULL;
            wdog_overflow_exp <=
                obcl_ovf_exp(opt_wd_r[`OBCL_WD_OVF_HI:`OBCL_WD_OVF_LO]);
            // [R6] Run at reset
            // [R8] Standby gating
            // [R9] Self-programming never gates
            wdog_count_en <= loaded_r & opt_wd_r[`OBCL_WD_RUN] &
                ~(standby & ~opt_wd_r[`OBCL_WD_STBY]);
        end
    end

    // Debug decode; code 01 is prohibited and treated as disabled.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_enable <= 1'b0;
            dbg_erase_on_fail <= 1'b0;
        end else begin
            // [R16] Debug decode
            dbg_enable <= loaded_r & dbg_mode[2];
            dbg_erase_on_fail <= loaded_r & dbg_mode[1];
        end
    end

    // Detect-on is software writable; the load wins over a write.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detect_on_r <= 1'b0;
        end else if (load) begin
            // [R10] Default start
            // [R13] Re-set on start
            detect_on_r <= ~lv_byte[`OBCL_LV_OFF];
        end else if (wr & dec[D_CTRL]) begin
            detect_on_r <= pwdata[0];
        end
    end

    // [R14] Unreliable window
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvd_unreliable <= 1'b0;
            settle_cnt_r <= 16'h0000;
        end else if (load) begin
            lvd_unreliable <= rst_by_wdog_or_illegal &
                              ~lv_byte[`OBCL_LV_OFF];
            settle_cnt_r <= 16'h0000;
        end else if (settle_end) begin
            lvd_unreliable <= 1'b0;
        end else if (lvd_unreliable) begin
            settle_cnt_r <= settle_cnt_r + 16'h0001;
        end
    end

    // Sticky status: a hardware set wins over a software clear.
    reg [3:0] status_set;
    always @* begin
        status_set = 4'h0;
        status_set[`OBCL_ST_LOADED] = load;
        status_set[`OBCL_ST_PATERR] = load & pat_err;
        status_set[`OBCL_ST_DBGBAD] = load & dbg_bad;
        status_set[`OBCL_ST_LVDOK] = settle_end;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= `OBCL_STATUS_RST;
        end else begin
            status_r <= (status_r & ~status_clr) | status_set;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `OBCL_MASK_RST;
        end else if (wr & dec[D_MASK]) begin
            mask_r <= pwdata[3:0];
        end
    end

    // Level interrupt, registered so the pin comes from a flip-flop.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    // APB slave: one wait state, read data registered with pready.
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (1'b1)
            dec[D_STATUS]: rd_mux = {28'h0000000, status_r};
            dec[D_MASK]: rd_mux = {28'h0000000, mask_r};
            dec[D_CTRL]: rd_mux = {31'h00000000, detect_on_r};
            dec[D_CONFIG]: rd_mux = {
                16'h0000,
                swap_used,
                dbg_erase_on_fail,
                dbg_enable,
                lvd_unreliable,
                lvd_enable,
                wdog_overflow_exp,
                wdog_window_sel,
                wdog_interval_irq_en,
                wdog_count_en,
                cpu_release,
                loaded_r
            };
            dec[D_WDOG]: rd_mux = {24'h000000, opt_wd_r};
            dec[D_LVD]: rd_mux = {24'h000000, opt_lv_r};
            dec[D_RSVD]: rd_mux = {24'h000000, opt_rs_r};
            dec[D_DBG]: rd_mux = {24'h000000, opt_dbg_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_rd;
            prdata <= (setup_rd & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // Unmapped addresses and writes to read-only bytes error out.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_rd & (unmapped | (pwrite & ro_hit));
        end
    end
endmodule

//--- tb/obcl_top_sva.sv
`timescale 1ns/100ps
module obcl_checker #(
    parameter [15:0] LVD_SETTLE_CYC = 16'h9C40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic boot_swap,
    input wire logic flash_rd,
    input wire logic [19:0] flash_addr,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_rvalid,
    input wire logic cpu_halt,
    input wire logic cpu_stop,
    input wire logic cpu_release,
    input wire logic wdog_count_en,
    input wire logic wdog_interval_irq_en,
    input wire logic [1:0] wdog_window_sel,
    input wire logic [4:0] wdog_overflow_exp,
    input wire logic lvd_enable,
    input wire logic lvd_unreliable,
    input wire logic dbg_enable,
    input wire logic dbg_erase_on_fail,
    input wire logic irq
);
    localparam logic [4:0] OVF [8] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F,
        5'h11, 5'h12, 5'h14};
    logic [7:0] sh_r [4];
    logic [15:0] hi_r;
    wire [7:0] wd = sh_r[0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Shadow of the accepted bytes, so the decode is judged by content.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_r <= 16'h0000;
        end else begin
            if (flash_rd && flash_rvalid) begin
                sh_r[flash_addr[1:0]] <= flash_rdata;
            end
            hi_r <= lvd_unreliable ? hi_r + 16'h0001 : 16'h0000;
        end
    end
    a_first_addr: assert property ($rose(flash_rd) |->
        flash_addr == (boot_swap ? 20'h010C0 : 20'h000C0))
        else $error("first flash address wrong");
    a_addr_step: assert property (flash_rd && flash_rvalid &&
        flash_addr[1:0] != 2'h3 |=> flash_rd &&
        flash_addr == $past(flash_addr) + 20'h00001)
        else $error("flash address did not step");
    a_no_early_go: assert property (flash_rd |-> !cpu_release)
        else $error("cpu released during fetch");
    a_release_hold: assert property (cpu_release |=> cpu_release)
        else $error("cpu release dropped");
    a_cfg_stable: assert property (cpu_release ##1 cpu_release |->
        $stable(wdog_overflow_exp) && $stable(wdog_window_sel) &&
        $stable(dbg_enable) && $stable(wdog_interval_irq_en))
        else $error("configuration changed after load");
    a_irq_select: assert property (cpu_release |->
        wdog_interval_irq_en == wd[7])
        else $error("interval interrupt enable wrong");
    a_window_map: assert property (cpu_release && wd[0] |->
        wdog_window_sel == wd[6:5])
        else $error("window select wrong");
    a_window_full: assert property (cpu_release && !wd[0] |->
        wdog_window_sel == 2'h3)
        else $error("window not forced full");
    a_ovf_map: assert property (cpu_release |->
        wdog_overflow_exp == OVF[wd[3:1]])
        else $error("overflow exponent wrong");
    a_count_gate: assert property (cpu_release ##1 cpu_release |->
        wdog_count_en == (wd[4] &&
        !(($past(cpu_halt) || $past(cpu_stop)) && !wd[0])))
        else $error("watchdog count enable wrong");
    a_lvd_default: assert property ($rose(cpu_release) |->
        lvd_enable == !sh_r[1][0])
        else $error("detector default wrong");
    a_dbg_decode: assert property (cpu_release |->
        dbg_enable == sh_r[3][7] &&
        dbg_erase_on_fail == (sh_r[3][7] && !sh_r[3][0]))
        else $error("debug decode wrong");
    a_settle_len: assert property ($fell(lvd_unreliable) |->
        hi_r == LVD_SETTLE_CYC)
        else $error("settle window length wrong");
    c_loaded: cover property ($rose(cpu_release));
    c_refused: cover property (pready && pslverr);
    c_settle: cover property ($fell(lvd_unreliable));
    c_irq: cover property ($rose(irq));
endmodule

//--- tb/obcl_top_tb.sv
`timescale 1ns/100ps
module obcl_top_tb;
    localparam logic [4:0] OVF [8] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F,
        5'h11, 5'h12, 5'h14};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic boot_swap = 1'b0, rst_by_wdog_or_illegal = 1'b0;
    logic cpu_halt = 1'b0, cpu_stop = 1'b0, flash_rvalid = 1'b0, go;
    logic [7:0] flash_rdata = 8'h00;
    logic [7:0] pri [4], alt [4];
    logic [32:0] exp_q [$], msk_q [$], e, m;
    wire pready, pslverr, flash_rd, cpu_release, wdog_count_en, irq;
    wire wdog_interval_irq_en, lvd_enable, lvd_unreliable;
    wire dbg_enable, dbg_erase_on_fail;
    wire [31:0] prdata;
    wire [19:0] flash_addr;
    wire [1:0] wdog_window_sel;
    wire [4:0] wdog_overflow_exp;
    int fails = 0, check_count = 0, seed = 18332;
    always #2.5 pclk = ~pclk;
    obcl_top #(.LVD_SETTLE_CYC(16'h0014)) dut_u (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .boot_swap(boot_swap), .flash_rd(flash_rd),
        .flash_addr(flash_addr), .flash_rdata(flash_rdata),
        .flash_rvalid(flash_rvalid),
        .rst_by_wdog_or_illegal(rst_by_wdog_or_illegal),
        .cpu_halt(cpu_halt), .cpu_stop(cpu_stop), .cpu_release(cpu_release),
        .wdog_count_en(wdog_count_en),
        .wdog_interval_irq_en(wdog_interval_irq_en),
        .wdog_window_sel(wdog_window_sel),
        .wdog_overflow_exp(wdog_overflow_exp), .lvd_enable(lvd_enable),
        .lvd_unreliable(lvd_unreliable), .dbg_enable(dbg_enable),
        .dbg_erase_on_fail(dbg_erase_on_fail), .irq(irq));
    task automatic chk(input string nm, input logic [32:0] x,
        input logic [32:0] g);
        check_count++;
        if (g !== x) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, x, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Flash answers at random pace; idle data is inverted, never stale.
    always @(posedge pclk) begin
        go = flash_rd && !flash_rvalid && ($random(seed) & 1) != 0;
        flash_rvalid <= go;
        flash_rdata <= !go ? ~flash_rdata :
            flash_addr[12] ? alt[flash_addr[1:0]] : pri[flash_addr[1:0]];
    end
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk("apb", e & m, {pslverr, prdata} & m);
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [32:0] x, input logic [32:0] k);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        exp_q.push_back(x);
        msk_q.push_back(k);
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 1'b1, pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] x,
        input logic [32:0] k);
        apb(1'b0, a, 32'h00000000, x, k);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic err);
        apb(1'b1, a, d, {err, 32'h00000000}, 33'h100000000);
    endtask
    task automatic load(input logic sw, input logic cause);
        int n;
        boot_swap <= sw;
        rst_by_wdog_or_illegal <= cause;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (cpu_release !== 1'b1 && n < 200);
        chk("cpu_release", 1'b1, cpu_release);
        @(posedge pclk);
    endtask
    initial begin
        #50000;
        chk("timeout", 1'b0, 1'b1);
        stop_test();
    end
    initial begin
        logic [7:0] c [4];
        logic [1:0] w;
        logic cen;
        logic [31:0] r;
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            c[0] = {r[7:4], i[2:0], r[0]};
            c[1] = {7'h7F, i[1]};
            c[2] = (i == 5) ? 8'hFE : 8'hFF;
            c[3] = {i[1], 6'h02, i[0]};
            foreach (c[k]) pri[k] = i[2] ? ~c[k] : c[k];
            foreach (c[k]) alt[k] = i[2] ? c[k] : ~c[k];
            cpu_halt <= r[8];
            cpu_stop <= r[9];
            load(i[2], 1'b0);
            w = c[0][0] ? c[0][6:5] : 2'h3;
            cen = c[0][4] && !((r[8] || r[9]) && !c[0][0]);
            chk("window", w, wdog_window_sel);
            chk("ovf", OVF[c[0][3:1]], wdog_overflow_exp);
            chk("irq_en", c[0][7], wdog_interval_irq_en);
            chk("count_en", cen, wdog_count_en);
            chk("lvd_en", !c[1][0], lvd_enable);
            chk("dbg", {c[3][7], c[3][7] & ~c[3][0]},
                {dbg_enable, dbg_erase_on_fail});
            foreach (c[k]) pri[k] = ~pri[k];
            rd(12'h00C, {16'h0000, i[2], c[3][7] & ~c[3][0], c[3][7], 1'b0,
                ~c[1][0], OVF[c[0][3:1]], w, c[0][7], cen, 2'h3},
                {33{1'b1}});
            for (int k = 0; k < 4; k++) rd(12'h300 + 12'(4 * k), c[k],
                {33{1'b1}});
            rd(12'h000, {~c[3][7] & c[3][0], i == 5, 1'b1},
                33'h100000007);
        end
        chk("irq", 1'b0, irq);
        wr(12'h004, 32'h00000001, 1'b0);
        repeat (2) @(posedge pclk);
        chk("irq", 1'b1, irq);
        wr(12'h000, 32'h00000001, 1'b0);
        repeat (2) @(posedge pclk);
        chk("irq", 1'b0, irq);
        rd(12'h000, 33'h0, 33'h100000001);
        rd(12'h100, 33'h100000000, {33{1'b1}});
        wr(12'h00C, 32'h0000FFFF, 1'b1);
        wr(12'h300, 32'h00000000, 1'b1);
        wr(12'h008, 32'h00000000, 1'b0);
        repeat (2) @(posedge pclk);
        chk("lvd_en", 1'b0, lvd_enable);
        rd(12'h008, 33'h0, 33'h100000001);
        pri[1] = 8'hFE;
        load(1'b0, 1'b1);
        chk("lvd_en", 1'b1, lvd_enable);
        chk("unrel", 1'b1, lvd_unreliable);
        repeat (20) @(posedge pclk);
        chk("unrel", 1'b0, lvd_unreliable);
        stop_test();
    end
endmodule
bind obcl_top obcl_checker #(.LVD_SETTLE_CYC(LVD_SETTLE_CYC)) chk_u (
    .pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
    .boot_swap(boot_swap), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid),
    .cpu_halt(cpu_halt), .cpu_stop(cpu_stop), .cpu_release(cpu_release),
    .wdog_count_en(wdog_count_en),
    .wdog_interval_irq_en(wdog_interval_irq_en),
    .wdog_window_sel(wdog_window_sel),
    .wdog_overflow_exp(wdog_overflow_exp), .lvd_enable(lvd_enable),
    .lvd_unreliable(lvd_unreliable), .dbg_enable(dbg_enable),
    .dbg_erase_on_fail(dbg_erase_on_fail), .irq(irq));
